// ### eag_regs.svh
`ifndef EAG_REGS_SVH
`define EAG_REGS_SVH

// ****************************************************************
// instruction set figures
// ****************************************************************
`define EAG_NUM_INSTR 62
`define EAG_NUM_MODES 8

// ****************************************************************
// instruction lengths in bytes, opcode included
// ****************************************************************
`define EAG_LEN_INH 2'h1
`define EAG_LEN_IMM 2'h2
`define EAG_LEN_DIR 2'h2
`define EAG_LEN_EXT 2'h3
`define EAG_LEN_IX 2'h1
`define EAG_LEN_IX1 2'h2
`define EAG_LEN_IX2 2'h3
`define EAG_LEN_REL 2'h2

// ****************************************************************
// address forming constants and reset values
// ****************************************************************
`define EAG_PAGE0_HIGH 8'h00
`define EAG_ADDR_RST 16'h0000
`define EAG_BYTE_RST 8'h00
`define EAG_FIRST_OPND 16'h0001
`define EAG_SECOND_OPND 16'h0002

`endif

// ### eag_pkg.sv
package eag_pkg;

    // addressing modes, eight of them
    typedef enum logic [2:0] {
        MODE_INH,
        MODE_IMM,
        MODE_DIR,
        MODE_EXT,
        MODE_IX,
        MODE_IX1,
        MODE_IX2,
        MODE_REL
    } eag_mode_type;

    // sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_CALC
    } eag_state_type;

endpackage

// ### eag_arith_if.sv
`timescale 1ns/100ps
// operands and results shared between the sequencer and its arithmetic units
interface eag_arith_if;
    logic [15:0] add_a;
    logic [15:0] add_b;
    logic [15:0] add_sum;
    logic [7:0] mul_a;
    logic [7:0] mul_b;
    logic [15:0] mul_p;

    modport adder (input add_a, input add_b, output add_sum);
    modport mult (input mul_a, input mul_b, output mul_p);
    modport user (output add_a, output add_b, input add_sum,
                  output mul_a, output mul_b, input mul_p);
endinterface

// ### eag_adder.sv
`timescale 1ns/100ps
// full-width address adder; no carry out, sums wrap at the top of memory
module eag_adder
(
    eag_arith_if.adder ar
);
    // ****************************************************************
    // sum
    // ****************************************************************
    // carry ripples into the high byte, so zero-page sums reach page one
    assign ar.add_sum = ar.add_a + ar.add_b;
endmodule // eag_adder

// ### eag_mult.sv
`timescale 1ns/100ps
// unsigned 8x8 multiplier, single cycle combinational
module eag_mult
(
    eag_arith_if.mult ar
);
    // ****************************************************************
    // product
    // ****************************************************************
    // both factors zero-extended, so no sign handling at all
    assign ar.mul_p = {8'h00, ar.mul_a} * {8'h00, ar.mul_b};
endmodule // eag_mult

// ### eag_top.sv
`timescale 1ns/100ps
`include "eag_regs.svh"
module eag_top #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic start,
    input wire eag_pkg::eag_mode_type mode,
    input wire logic is_mul,
    input wire logic branch_take,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] idx_in,
    input wire logic [15:0] pc_in,
    output logic mem_req,
    output logic [15:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack,
    output logic busy,
    output logic done,
    output logic [15:0] ea,
    output logic ea_valid,
    output logic [7:0] operand,
    output logic operand_valid,
    output logic [15:0] next_pc,
    output logic [1:0] instr_len,
    output logic regs_write,
    output logic [7:0] acc_out,
    output logic [7:0] idx_out
);

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    // the address forms assume an 8-bit data path and a 16-bit address space
    generate
        if (ADDR_W != 16 || DATA_W != 8)
        begin : g_bad_width
            $error("eag_top supports only 16-bit addresses and 8-bit data");
        end
        if (`EAG_NUM_MODES != 8 || `EAG_NUM_INSTR != 62)
        begin : g_bad_set
            $error("eag_top instruction set figures do not match the decoder");
        end
    endgenerate

    // ****************************************************************
    // reset synchroniser
    // ****************************************************************
    logic rst_meta_q;
    logic rst_sync_q;

    // release is synchronised, assertion stays asynchronous
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // ****************************************************************
    // declarations
    // ****************************************************************
    eag_pkg::eag_state_type state_q;
    eag_pkg::eag_mode_type mode_q;
    logic mul_q;
    logic take_q;
    logic [7:0] acc_q;
    logic [7:0] idx_q;
    logic [15:0] pc_q;
    logic [7:0] byte1_q;
    logic [7:0] byte2_q;
    logic [1:0] len_q;
    logic [1:0] left_q;
    logic fetch_idx_q;
    logic [15:0] npc_c;
    logic [15:0] rel_off_c;
    logic [1:0] start_len_c;

    eag_arith_if ar ();

    // ****************************************************************
    // arithmetic units
    // ****************************************************************
    eag_adder u_adder
    (
        .ar(ar.adder)
    );

    eag_mult u_mult
    (
        .ar(ar.mult)
    );

    // ****************************************************************
    // length decode
    // ****************************************************************
    // byte count per addressing mode, opcode included
    always_comb
    begin
        case (mode)
            eag_pkg::MODE_INH: start_len_c = `EAG_LEN_INH;
            eag_pkg::MODE_IMM: start_len_c = `EAG_LEN_IMM;
            eag_pkg::MODE_DIR: start_len_c = `EAG_LEN_DIR;
            eag_pkg::MODE_EXT: start_len_c = `EAG_LEN_EXT;
            eag_pkg::MODE_IX: start_len_c = `EAG_LEN_IX;
            eag_pkg::MODE_IX1: start_len_c = `EAG_LEN_IX1;
            eag_pkg::MODE_IX2: start_len_c = `EAG_LEN_IX2;
            eag_pkg::MODE_REL: start_len_c = `EAG_LEN_REL;
            default: start_len_c = `EAG_LEN_INH;
        endcase
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    // one opcode at a time; start is ignored while busy
    always_ff @(posedge mclk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            state_q <= eag_pkg::ST_IDLE;
            left_q <= 2'h0;
            fetch_idx_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                eag_pkg::ST_IDLE:
                begin
                    if (start)
                    begin
                        left_q <= start_len_c - 2'h1;
                        fetch_idx_q <= 1'b0;
                        // one-byte forms need no operand fetch
                        if (start_len_c == 2'h1)
                        begin
                            state_q <= eag_pkg::ST_CALC;
                        end
                        else
                        begin
                            state_q <= eag_pkg::ST_FETCH;
                        end
                    end
                end
                eag_pkg::ST_FETCH:
                begin
                    if (mem_ack)
                    begin
                        left_q <= left_q - 2'h1;
                        fetch_idx_q <= 1'b1;
                        if (left_q == 2'h1)
                        begin
                            state_q <= eag_pkg::ST_CALC;
                        end
                    end
                end
                eag_pkg::ST_CALC:
                begin
                    state_q <= eag_pkg::ST_IDLE;
                end
                default:
                begin
                    state_q <= eag_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // instruction capture
    // ****************************************************************
    // cpu state is sampled once at start, so it may change afterwards
    always_ff @(posedge mclk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            mode_q <= eag_pkg::MODE_INH;
            mul_q <= 1'b0;
            take_q <= 1'b0;
            acc_q <= `EAG_BYTE_RST;
            idx_q <= `EAG_BYTE_RST;
            pc_q <= `EAG_ADDR_RST;
            len_q <= `EAG_LEN_INH;
        end
        else if (state_q == eag_pkg::ST_IDLE && start)
        begin
            mode_q <= mode;
            mul_q <= is_mul;
            take_q <= branch_take;
            acc_q <= acc_in;
            idx_q <= idx_in;
            pc_q <= pc_in;
            len_q <= start_len_c;
        end
    end

    // ****************************************************************
    // operand byte fetch
    // ****************************************************************
    // bytes that follow the opcode, in program order
    always_ff @(posedge mclk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            byte1_q <= `EAG_BYTE_RST;
            byte2_q <= `EAG_BYTE_RST;
        end
        else if (state_q == eag_pkg::ST_FETCH && mem_ack)
        begin
            if (fetch_idx_q)
            begin
                byte2_q <= mem_rdata;
            end
            else
            begin
                byte1_q <= mem_rdata;
            end
        end
    end

    // request held until memory acknowledges
    assign mem_req = (state_q == eag_pkg::ST_FETCH);
    assign mem_addr = pc_q + (fetch_idx_q ? `EAG_SECOND_OPND : `EAG_FIRST_OPND);
    assign busy = (state_q != eag_pkg::ST_IDLE);

    // ****************************************************************
    // address arithmetic
    // ****************************************************************
    // following instruction, which is also the branch base
    assign npc_c = pc_q + {14'h0000, len_q};
    // sign extension of the displacement byte
    assign rel_off_c = {{8{byte1_q[7]}}, byte1_q};

    // adder operands picked by mode
    always_comb
    begin
        ar.add_a = npc_c;
        ar.add_b = 16'h0000;
        case (mode_q)
            eag_pkg::MODE_IX1:
            begin
                ar.add_a = {`EAG_PAGE0_HIGH, idx_q};
                ar.add_b = {`EAG_PAGE0_HIGH, byte1_q};
            end
            eag_pkg::MODE_IX2:
            begin
                ar.add_a = {`EAG_PAGE0_HIGH, idx_q};
                ar.add_b = {byte1_q, byte2_q};
            end
            eag_pkg::MODE_REL:
            begin
                ar.add_a = npc_c;
                // not taken adds nothing and falls through
                ar.add_b = take_q ? rel_off_c : 16'h0000;
            end
            default:
            begin
                ar.add_a = npc_c;
                ar.add_b = 16'h0000;
            end
        endcase
    end

    assign ar.mul_a = acc_q;
    assign ar.mul_b = idx_q;

    // ****************************************************************
    // effective address and operand results
    // ****************************************************************
    // all results registered, presented together with done
    always_ff @(posedge mclk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            ea <= `EAG_ADDR_RST;
            ea_valid <= 1'b0;
            operand <= `EAG_BYTE_RST;
            operand_valid <= 1'b0;
            next_pc <= `EAG_ADDR_RST;
            instr_len <= `EAG_LEN_INH;
        end
        else if (state_q == eag_pkg::ST_CALC)
        begin
            instr_len <= len_q;
            next_pc <= (mode_q == eag_pkg::MODE_REL) ? ar.add_sum : npc_c;
            operand <= byte1_q;
            operand_valid <= (mode_q == eag_pkg::MODE_IMM);
            case (mode_q)
                eag_pkg::MODE_DIR:
                begin
                    ea <= {`EAG_PAGE0_HIGH, byte1_q};
                    ea_valid <= 1'b1;
                end
                eag_pkg::MODE_EXT:
                begin
                    ea <= {byte1_q, byte2_q};
                    ea_valid <= 1'b1;
                end
                eag_pkg::MODE_IX:
                begin
                    ea <= {`EAG_PAGE0_HIGH, idx_q};
                    ea_valid <= 1'b1;
                end
                eag_pkg::MODE_IX1, eag_pkg::MODE_IX2:
                begin
                    ea <= ar.add_sum;
                    ea_valid <= 1'b1;
                end
                default:
                begin
                    // inherent, immediate and relative form no operand address
                    ea <= `EAG_ADDR_RST;
                    ea_valid <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // multiply results
    // ****************************************************************
    // only an inherent multiply writes the register pair back
    always_ff @(posedge mclk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            acc_out <= `EAG_BYTE_RST;
            idx_out <= `EAG_BYTE_RST;
            regs_write <= 1'b0;
        end
        else if (state_q == eag_pkg::ST_CALC)
        begin
            regs_write <= mul_q && (mode_q == eag_pkg::MODE_INH);
            acc_out <= ar.mul_p[7:0];
            idx_out <= ar.mul_p[15:8];
        end
        else
        begin
            regs_write <= 1'b0;
        end
    end

    // ****************************************************************
    // completion
    // ****************************************************************
    // done pulses for one cycle, in the cycle the results appear
    always_ff @(posedge mclk or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            done <= 1'b0;
        end
        else
        begin
            done <= (state_q == eag_pkg::ST_CALC);
        end
    end

endmodule // eag_top

// ### eag_properties.sv
`timescale 1ns/100ps
// ****************************************************************
// port checks of address forming, lengths and multiply
// ****************************************************************
module eag_properties #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
)
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic start,
    input wire eag_pkg::eag_mode_type mode,
    input wire logic is_mul,
    input wire logic branch_take,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] idx_in,
    input wire logic [15:0] pc_in,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_ack,
    input wire logic busy,
    input wire logic done,
    input wire logic [15:0] ea,
    input wire logic ea_valid,
    input wire logic [7:0] operand,
    input wire logic operand_valid,
    input wire logic [15:0] next_pc,
    input wire logic [1:0] instr_len,
    input wire logic regs_write,
    input wire logic [7:0] acc_out,
    input wire logic [7:0] idx_out
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    logic [2:0] m_q;
    logic mul_q, br_q, ev_exp;
    logic [7:0] a_q, x_q, b1_q, b2_q;
    logic [15:0] pc_q, ea_exp;
    logic [1:0] len_exp;

    // snapshot of the accepted instruction; refused starts leave it alone
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            {m_q, mul_q, br_q, a_q, x_q, pc_q} <= '0;
        else if (start && !busy)
            {m_q, mul_q, br_q, a_q, x_q, pc_q} <= {mode, is_mul, branch_take, acc_in, idx_in, pc_in};
    end

    // fetched bytes, sorted by address rather than by arrival
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            {b1_q, b2_q} <= '0;
        else if (mem_req && mem_ack && mem_addr == pc_q + 16'h0001)
            b1_q <= mem_rdata;
        else if (mem_req && mem_ack)
            b2_q <= mem_rdata;
    end

    // expected address and length of the held instruction
    always_comb
    begin
        ea_exp = 16'h0000;
        ev_exp = 1'b1;
        case (m_q)
            eag_pkg::MODE_DIR: ea_exp = {8'h00, b1_q};
            eag_pkg::MODE_EXT: ea_exp = {b1_q, b2_q};
            eag_pkg::MODE_IX: ea_exp = {8'h00, x_q};
            eag_pkg::MODE_IX1: ea_exp = {8'h00, x_q} + {8'h00, b1_q};
            eag_pkg::MODE_IX2: ea_exp = {b1_q, b2_q} + {8'h00, x_q};
            default: ev_exp = 1'b0;
        endcase
        case (m_q)
            eag_pkg::MODE_INH, eag_pkg::MODE_IX: len_exp = 2'h1;
            eag_pkg::MODE_EXT, eag_pkg::MODE_IX2: len_exp = 2'h3;
            default: len_exp = 2'h2;
        endcase
    end

    inh_no_fetch_a:
        assert property (start && !busy && mode == eag_pkg::MODE_INH
            |=> !mem_req ##1 (done && !mem_req)) else $error("inherent op fetched or late");
    fetch_first_a:
        assert property ($rose(mem_req) |-> mem_addr == pc_q + 16'h0001)
        else $error("first fetch not after opcode");
    byte_order_a:
        assert property (mem_req && mem_ack && mem_addr == pc_q + 16'h0001 && len_exp == 2'h3
            |=> mem_req && mem_addr == pc_q + 16'h0002) else $error("second byte not fetched next");
    last_ack_a:
        assert property (mem_req && mem_ack && mem_addr == pc_q + {14'h0, len_exp} - 16'h0001
            |-> !done ##2 done) else $error("done not two cycles after last byte");
    instr_len_a:
        assert property (done |-> instr_len == len_exp) else $error("wrong length");
    eff_address_a:
        assert property (done |-> ea == ea_exp && ea_valid == ev_exp) else $error("wrong ea");
    imm_operand_a:
        assert property (done |-> operand_valid == (m_q == eag_pkg::MODE_IMM)
            && (!operand_valid || operand == b1_q)) else $error("wrong immediate");
    branch_pc_a:
        assert property (done |-> next_pc == pc_q + {14'h0, len_exp}
            + ((m_q == eag_pkg::MODE_REL && br_q) ? {{8{b1_q[7]}}, b1_q} : 16'h0000))
        else $error("wrong next pc");
    product_write_a:
        assert property (done |-> {idx_out, acc_out} == {8'h00, a_q} * {8'h00, x_q}
            && regs_write == (mul_q && m_q == eag_pkg::MODE_INH)) else $error("wrong product");

    cover property (done && regs_write);
    cover property (done && m_q == eag_pkg::MODE_REL && br_q);
    cover property (done && m_q == eag_pkg::MODE_IX2);
endmodule // eag_properties

bind eag_top eag_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) eag_properties_inst (
    .mclk(mclk), .resetn(resetn), .start(start), .mode(mode), .is_mul(is_mul),
    .branch_take(branch_take), .acc_in(acc_in), .idx_in(idx_in), .pc_in(pc_in),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .busy(busy), .done(done), .ea(ea), .ea_valid(ea_valid), .operand(operand),
    .operand_valid(operand_valid), .next_pc(next_pc), .instr_len(instr_len),
    .regs_write(regs_write), .acc_out(acc_out), .idx_out(idx_out));

// ### eag_mem_model.sv
`timescale 1ns/100ps
// ****************************************************************
// program memory with a settable answer delay
// ****************************************************************
module eag_mem_model
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic mem_req,
    input wire logic [15:0] mem_addr,
    input wire logic [3:0] lag,
    output logic [7:0] mem_rdata,
    output logic mem_ack
);
    logic [7:0] store [0:255];
    logic [3:0] wait_q;
    logic [7:0] last_q;

    // ack after lag request cycles; lag 0 answers in the first one
    assign mem_ack = mem_req && wait_q == lag;
    // off the ack the lane shows the inverse of the last byte, so stale reads show
    assign mem_rdata = mem_ack ? store[mem_addr[7:0]] : ~last_q;

    // count request cycles until the answer
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            wait_q <= 4'h0;
        else if (mem_ack)
            wait_q <= 4'h0;
        else if (mem_req)
            wait_q <= wait_q + 4'h1;
    end

    // remember the byte handed over
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            last_q <= 8'h00;
        else if (mem_ack)
            last_q <= mem_rdata;
    end
endmodule // eag_mem_model

// ### test_effective_address_generator.sv
`timescale 1ns/100ps
// ****************************************************************
// bench for the effective address generator
// ****************************************************************
module test_effective_address_generator;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic start = 1'b0;
    eag_pkg::eag_mode_type mode = eag_pkg::MODE_INH;
    logic is_mul = 1'b0;
    logic branch_take = 1'b0;
    logic [7:0] acc_in = 8'h00;
    logic [7:0] idx_in = 8'h00;
    logic [15:0] pc_in = 16'h0000;
    logic [3:0] lag = 4'h0;
    logic mem_req, mem_ack, busy, done, ea_valid, operand_valid, regs_write;
    logic [15:0] mem_addr, ea, next_pc;
    logic [7:0] mem_rdata, operand, acc_out, idx_out;
    logic [1:0] instr_len;
    int bad_count = 0;
    int checks_done = 0;

    always #10 mclk = ~mclk;

    eag_top eag_top_inst (.mclk(mclk), .resetn(resetn), .start(start), .mode(mode),
        .is_mul(is_mul), .branch_take(branch_take), .acc_in(acc_in), .idx_in(idx_in),
        .pc_in(pc_in), .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .busy(busy), .done(done), .ea(ea), .ea_valid(ea_valid),
        .operand(operand), .operand_valid(operand_valid), .next_pc(next_pc),
        .instr_len(instr_len), .regs_write(regs_write), .acc_out(acc_out), .idx_out(idx_out));
    eag_mem_model eag_mem_model_inst (.mclk(mclk), .resetn(resetn), .mem_req(mem_req),
        .mem_addr(mem_addr), .lag(lag), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // run one instruction; poke repeats start while busy, which must be ignored
    task automatic exec(input eag_pkg::eag_mode_type m, input logic mul, input logic br,
        input logic [7:0] a, input logic [7:0] x, input logic [15:0] pc,
        input logic [7:0] b1, input logic [7:0] b2, input logic [3:0] w, input logic poke);
        logic [1:0] len;
        logic [15:0] e;
        int n;
        len = (m == eag_pkg::MODE_INH || m == eag_pkg::MODE_IX) ? 2'h1
            : (m == eag_pkg::MODE_EXT || m == eag_pkg::MODE_IX2) ? 2'h3 : 2'h2;
        e = m == eag_pkg::MODE_DIR ? {8'h00, b1} : m == eag_pkg::MODE_EXT ? {b1, b2}
            : m == eag_pkg::MODE_IX ? {8'h00, x} : m == eag_pkg::MODE_IX1 ? {8'h00, x} + b1
            : m == eag_pkg::MODE_IX2 ? {b1, b2} + {8'h00, x} : 16'h0000;
        eag_mem_model_inst.store[pc[7:0] + 8'h01] = b1;
        eag_mem_model_inst.store[pc[7:0] + 8'h02] = b2;
        @(posedge mclk);
        lag <= w;
        start <= 1'b1;
        mode <= m;
        is_mul <= mul;
        branch_take <= br;
        acc_in <= a;
        idx_in <= x;
        pc_in <= pc;
        @(posedge mclk);
        start <= poke;
        mode <= eag_pkg::MODE_INH;
        @(posedge mclk);
        start <= 1'b0;
        n = 0;
        @(negedge mclk);
        while (done !== 1'b1 && n < 40)
        begin
            @(negedge mclk);
            n++;
        end
        chk("done", 16'h0001, {15'h0, done});
        chk("length", {14'h0, len}, {14'h0, instr_len});
        chk("ea", e, ea);
        chk("ea_valid", {15'h0, m inside {[eag_pkg::MODE_DIR:eag_pkg::MODE_IX2]}},
            {15'h0, ea_valid});
        chk("imm_valid", {15'h0, m == eag_pkg::MODE_IMM}, {15'h0, operand_valid});
        if (m == eag_pkg::MODE_IMM)
            chk("operand", {8'h00, b1}, {8'h00, operand});
        chk("next_pc", pc + len + ((m == eag_pkg::MODE_REL && br) ? {{8{b1[7]}}, b1} : 16'h0),
            next_pc);
        chk("product", {8'h00, a} * {8'h00, x}, {idx_out, acc_out});
        chk("regs_write", {15'h0, mul && m == eag_pkg::MODE_INH}, {15'h0, regs_write});
        repeat (poke ? 4 : 0)
        begin
            @(negedge mclk);
            chk("no_extra_done", 16'h0000, {15'h0, done});
        end
    endtask

    // every addressing mode once
    task automatic test_modes;
        eag_pkg::eag_mode_type m;
        m = eag_pkg::MODE_INH;
        repeat (8)
        begin
            exec(m, 1'b0, 1'b1, 8'h21, 8'h43, 16'h1000, 8'h5A, 8'h3C, 4'h0, 1'b0);
            m = m.next();
        end
        $display("test_modes done");
    endtask

    // products at the extremes; multiply flag only counts for inherent
    task automatic test_mul;
        exec(eag_pkg::MODE_INH, 1'b1, 1'b0, 8'hFF, 8'hFF, 16'h0200, 8'h00, 8'h00, 4'h0, 1'b0);
        exec(eag_pkg::MODE_INH, 1'b1, 1'b0, 8'h12, 8'h34, 16'h0300, 8'h00, 8'h00, 4'h1, 1'b0);
        exec(eag_pkg::MODE_IX, 1'b1, 1'b0, 8'h05, 8'h07, 16'h0400, 8'h00, 8'h00, 4'h0, 1'b0);
        $display("test_mul done");
    endtask

    // sums at the top of each range, with slow memory
    task automatic test_bounds;
        exec(eag_pkg::MODE_IX1, 1'b0, 1'b0, 8'h00, 8'hFF, 16'h0500, 8'hFF, 8'h00, 4'h2, 1'b0);
        exec(eag_pkg::MODE_IX, 1'b0, 1'b0, 8'h00, 8'hFF, 16'h0600, 8'h00, 8'h00, 4'h0, 1'b0);
        exec(eag_pkg::MODE_DIR, 1'b0, 1'b0, 8'h00, 8'h77, 16'h0700, 8'hFF, 8'h00, 4'h3, 1'b0);
        exec(eag_pkg::MODE_IX2, 1'b0, 1'b0, 8'h00, 8'h80, 16'hFFFE, 8'hFF, 8'hC0, 4'h3, 1'b0);
        exec(eag_pkg::MODE_EXT, 1'b0, 1'b0, 8'h00, 8'h00, 16'hFFFE, 8'hAB, 8'hCD, 4'h1, 1'b0);
        $display("test_bounds done");
    endtask

    // branch reach both ways, and a not-taken branch
    task automatic test_branch;
        exec(eag_pkg::MODE_REL, 1'b0, 1'b1, 8'h00, 8'h00, 16'h2000, 8'h7F, 8'h00, 4'h0, 1'b0);
        exec(eag_pkg::MODE_REL, 1'b0, 1'b1, 8'h00, 8'h00, 16'h2000, 8'h80, 8'h00, 4'h2, 1'b0);
        exec(eag_pkg::MODE_REL, 1'b0, 1'b0, 8'h00, 8'h00, 16'h2000, 8'h80, 8'h00, 4'h0, 1'b0);
        $display("test_branch done");
    endtask

    // a start while busy must not disturb the running fetch
    task automatic test_refused;
        exec(eag_pkg::MODE_EXT, 1'b0, 1'b0, 8'h00, 8'h00, 16'h0800, 8'h12, 8'h34, 4'h2, 1'b1);
        $display("test_refused done");
    endtask

    // reset in mid fetch clears the outputs, then a clean instruction runs
    task automatic test_reset;
        @(posedge mclk);
        start <= 1'b1;
        mode <= eag_pkg::MODE_IX2;
        lag <= 4'h5;
        @(posedge mclk);
        start <= 1'b0;
        @(posedge mclk);
        resetn <= 1'b0;
        @(negedge mclk);
        chk("busy_rst", 16'h0000, {15'h0, busy});
        chk("req_rst", 16'h0000, {15'h0, mem_req});
        chk("addr_rst", 16'h0001, mem_addr);
        chk("len_rst", 16'h0001, {14'h0, instr_len});
        chk("ea_rst", 16'h0000, ea);
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        exec(eag_pkg::MODE_DIR, 1'b0, 1'b0, 8'h00, 8'h00, 16'h3000, 8'h44, 8'h00, 4'h0, 1'b0);
        $display("test_reset done");
    endtask

    initial
    begin
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        repeat (3) @(posedge mclk);
        test_modes;
        test_mul;
        test_bounds;
        test_branch;
        test_refused;
        test_reset;
        results;
    end

    // 21 instructions of at most 20 cycles each fit well inside this
    initial
    begin
        #100000;
        bad_count++;
        results;
    end
endmodule // test_effective_address_generator
